// ===== verilog/rtcco_pkg.sv
// Purpose: Shared constants and types for the clock output and offset correction block
// Assumes: 8-bit registers, each on one aligned 32-bit Wishbone word
// Notes: Crystal ticks are 32768 Hz edges seen through a synchroniser

package rtcco_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_OFFSET = 6'h0D; // Frequency offset control
	localparam logic [5:0] IDX_TIMER = 6'h0E; // Timer and clock output control
	localparam logic [5:0] IDX_STATUS = 6'h10; // Sticky event flags, write one to clear
	localparam logic [5:0] IDX_MASK = 6'h11; // Interrupt mask
	localparam logic [5:0] IDX_CTRL = 6'h12; // Halt and correction pulse enable
	localparam logic [5:0] IDX_PENDING = 6'h13; // Corrections still to schedule

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_HALT = 0; // Time halt: stops prescaler stages 2 to 14
	localparam int CTL_CIE = 1; // Correction pulse output enable
	localparam int EV_CORR = 0; // A correction pulse was applied
	localparam int EV_TRIG = 1; // A correction sequence was triggered
	localparam int EV_MIN = 2; // A minute boundary passed
	localparam int NUM_EV = 3;
	localparam logic [7:0] OFFSET_RST = 8'h00; // Normal mode, no correction
	localparam logic [7:0] TIMER_RST = 8'h00; // 32768 Hz output enabled
	localparam logic [7:0] TIMER_WMASK = 8'h7B; // Bits 7 and 2 are reserved
	localparam logic [2:0] FSEL_OFF = 3'h7; // Output disabled, pin floats

	// ----------------------------------------
	// Timing constants
	// ----------------------------------------
	localparam int XTAL_HZ = 32768; // Nominal crystal rate
	localparam int CORR_PULSE_DIV = 128; // Correction pulse lasts 1/128 s
	localparam logic [8:0] CORR_PULSE_TICKS = 9'(XTAL_HZ / CORR_PULSE_DIV);
	localparam logic [5:0] SEC_LAST = 6'h3B; // Last second of a minute (59)
	localparam logic [5:0] MIN_LAST = 6'h3B; // Last minute of an hour (59)

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic coarse; // 1: hourly trigger, 0: every two hours
		logic [6:0] value; // Two's complement step count
	} rtcco_offs_t;

	typedef struct packed {
		logic rsv7;
		logic [2:0] freq_sel; // output_frequency_select
		logic run; // countdown_run_bit, stored only
		logic rsv2;
		logic [1:0] src_sel; // countdown_source_select, stored only
	} rtcco_tmr_t;

	typedef enum logic [1:0] {
		CS_IDLE = 2'b01, // No correction sequence under way
		CS_RUN = 2'b10 // Corrections remain to be applied
	} rtcco_cstate_t;

	// Magnitude of a 7-bit two's complement value (-64 gives 64)
	function automatic logic [6:0] rtcco_mag(input logic [6:0] v);
		rtcco_mag = v[6] ? 7'(~v + 7'h01) : v;
	endfunction

endpackage

// ===== verilog/rtcco_top.sv
// Purpose: Square wave clock output and frequency offset correction of a real-time clock
// Assumes: XTAL_IN is the 32768 Hz crystal level, asynchronous to SYS_CLK
// Notes: Registers on classic Wishbone, one 8-bit register per word

`timescale 1ns/1ps

// Functional notes
// - Bits 6-4 pick 32768/16384/8192/4096 Hz
// - Codes 4-6 give 2048/1024/1 Hz; 7 floats
// - Power-on: output enabled, open drain, 32768 Hz
// - All but top frequency have 50:50 duty
// - Halt holds 2048/1024/1 Hz output low
// - Enable pin low floats output like code 7
// - 1 Hz output shows correction pulses
// - Offset bit 7: two-hourly or hourly trigger
// - Step is 2.17 or 4.34 ppm
// - Offset is 7-bit two's complement, default zero
// - Each correction adds or removes one 64 Hz pulse
// - Normal: one pulse per minute until done
// - Coarse: one pulse per minute, up to 60
// - Coarse: surplus beyond 60 in minute 59
// - Active-low 1/128 s pulse per correction
// - Halt resets prescaler stages 2 to 14
// - Correction only touches 1 Hz and slower
module rtcco_top
	import rtcco_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic XTAL_IN,
	input wire logic OUTPUT_ENABLE_PIN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic IRQ,
	output logic SQUARE_WAVE_OUTPUT_PIN_O,
	output logic SQUARE_WAVE_OUTPUT_PIN_OE_N,
	output logic CORRECTION_INT_N
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic x_s1_r, x_s2_r, x_s3_r; // Crystal synchroniser and edge stage
	logic en_s1_r, en_s2_r; // Enable pin synchroniser
	logic [4:0] free_r; // Prescaler stages that halt never stops
	logic [6:0] tb_hi_r; // Stages 2 to 8, held by halt
	logic [5:0] sub_r, sub_nxt; // 64 Hz stages of the seconds chain
	logic [5:0] sec_r, min_r; // Seconds and minutes of the hour
	logic hr_r; // Hour parity for the two-hour trigger
	rtcco_offs_t offs_r; // Offset register
	rtcco_tmr_t tmr_r; // Timer and clock output register
	logic [1:0] ctl_r; // Halt and pulse enable
	logic [NUM_EV-1:0] stat_r, mask_r; // Event flags and their mask
	rtcco_cstate_t cs_r, cs_nxt; // Correction sequencer
	logic sign_l_r, coarse_l_r; // Offset latched at the trigger
	logic [6:0] remain_r, remain_nxt; // Pulses still to schedule
	logic [6:0] burst_r, burst_nxt; // Pulses due in this minute
	logic [8:0] pulse_cnt_r; // Remaining crystal ticks of the INT pulse
	logic int_n_r, oe_n_r; // Registered pin levels
	logic ack_r;
	logic [31:0] rdat_r;

	// ----------------------------------------
	// Decoding and selection
	// ----------------------------------------
	wire tick32 = x_s2_r & ~x_s3_r; // One crystal period has passed
	wire halt = ctl_r[CTL_HALT];
	wire tb_carry = tick32 & (free_r[1:0] == 2'h3); // Carry into stage 2
	wire tick64 = tb_carry & (tb_hi_r == 7'h7F) & ~halt; // 64 Hz seconds-chain clock
	wire corr_fire = tick64 & (burst_r != 7'h00); // Apply one correction now
	// A removed pulse freezes the chain, an added one doubles the step
	wire [1:0] step = !corr_fire ? 2'h1 : (sign_l_r ? 2'h0 : 2'h2);
	wire [6:0] sub_sum = {1'b0, sub_r} + {5'h00, step};
	wire sec_tick = tick64 & sub_sum[6]; // Corrected 1 Hz tick
	wire min_tick = sec_tick & (sec_r == SEC_LAST); // Corrected 1/60 Hz tick
	wire [5:0] min_new = (min_r == MIN_LAST) ? 6'h00 : 6'(min_r + 6'h01);
	wire hr_new = (min_r == MIN_LAST) ? ~hr_r : hr_r;
	// Coarse triggers each hour, normal only on even hours
	wire trig = min_tick & (min_new == 6'h00) & (offs_r.coarse | ~hr_new);
	wire [6:0] mag_live = rtcco_mag(offs_r.value); // One pulse per step
	wire [6:0] rem_src = trig ? mag_live : remain_r;
	wire coarse_src = trig ? offs_r.coarse : coarse_l_r;
	wire last_min = coarse_src & (min_new == MIN_LAST);
	// One pulse per minute; coarse minute 59 takes all that is left
	wire [6:0] burst_load = (rem_src == 7'h00) ? 7'h00 :
		(last_min ? rem_src : 7'h01);

	// Bus decode
	wire wb_req = WB_CYC_I & WB_STB_I & ~ack_r;
	wire [5:0] idx = WB_ADR_I[7:2];
	wire wr_lo = wb_req & WB_WE_I & WB_SEL_I[0];
	wire wr_offs = wr_lo & (idx == IDX_OFFSET);
	wire wr_tmr = wr_lo & (idx == IDX_TIMER);
	wire wr_stat = wr_lo & (idx == IDX_STATUS);
	wire wr_mask = wr_lo & (idx == IDX_MASK);
	wire wr_ctl = wr_lo & (idx == IDX_CTRL);
	wire [7:0] rd_byte;
	assign rd_byte = (idx == IDX_OFFSET) ? offs_r :
		(idx == IDX_TIMER) ? tmr_r :
		(idx == IDX_STATUS) ? {5'h00, stat_r} :
		(idx == IDX_MASK) ? {5'h00, mask_r} :
		(idx == IDX_CTRL) ? {6'h00, ctl_r} :
		(idx == IDX_PENDING) ? {1'b0, remain_r} : 8'h00; // Unmapped reads zero

	// Events that set sticky flags
	wire [NUM_EV-1:0] ev = {min_tick, trig, corr_fire};

	// Square wave selection; 2048 Hz and below stop low under halt
	function automatic logic wave_sel(input logic [2:0] sel, input logic xl,
		input logic [4:0] fr, input logic one_hz, input logic hlt);
		case (sel)
			3'h0: wave_sel = xl; // Raw crystal, duty not controlled
			3'h1: wave_sel = fr[0]; // Divider stages are 50:50
			3'h2: wave_sel = fr[1];
			3'h3: wave_sel = fr[2]; // Unaffected by halt
			3'h4: wave_sel = fr[3] & ~hlt;
			3'h5: wave_sel = fr[4] & ~hlt;
			3'h6: wave_sel = one_hz & ~hlt; // Corrected 1 Hz
			default: wave_sel = 1'b1; // Code 7: released
		endcase
	endfunction

	// Disabled by code 7 or by the enable pin; otherwise pull low on low phase
	wire out_on = en_s2_r & (tmr_r.freq_sel != FSEL_OFF);
	wire wave = wave_sel(tmr_r.freq_sel, x_s2_r, free_r, sub_r[5], halt);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	// Pins are asynchronous; the first stage is read only by the second
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			x_s1_r <= 1'b0;
			x_s2_r <= 1'b0;
			x_s3_r <= 1'b0;
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end else begin
			x_s1_r <= XTAL_IN;
			x_s2_r <= x_s1_r;
			x_s3_r <= x_s2_r;
			en_s1_r <= OUTPUT_ENABLE_PIN;
			en_s2_r <= en_s1_r;
		end
	end

	// ----------------------------------------
	// Prescaler and time base
	// ----------------------------------------
	// Lower stages free run so high output rates survive halt
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			free_r <= 5'h00;
		end else if (tick32) begin
			free_r <= 5'(free_r + 5'h01);
		end
	end

	// Stages 2 to 8 feed the seconds chain and are cleared by halt
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tb_hi_r <= 7'h00;
		end else if (halt) begin
			tb_hi_r <= 7'h00;
		end else if (tb_carry) begin
			tb_hi_r <= 7'(tb_hi_r + 7'h01);
		end
	end

	// 64 Hz stages; sub_r[5] is the 1 Hz square wave
	always_comb begin
		sub_nxt = sub_r;
		if (halt) begin
			sub_nxt = 6'h00;
		end else if (tick64) begin
			sub_nxt = sub_sum[5:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sub_r <= 6'h00;
		end else begin
			sub_r <= sub_nxt;
		end
	end

	// Seconds, minutes and hour parity from the corrected tick
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sec_r <= 6'h00;
			min_r <= 6'h00;
			hr_r <= 1'b0;
		end else if (sec_tick) begin
			sec_r <= (sec_r == SEC_LAST) ? 6'h00 : 6'(sec_r + 6'h01);
			if (min_tick) begin
				min_r <= min_new;
				hr_r <= hr_new;
			end
		end
	end

	// ----------------------------------------
	// Correction sequencer
	// ----------------------------------------
	// Offset is sampled only at the trigger so a rewrite cannot upset a run
	always_comb begin
		cs_nxt = cs_r;
		remain_nxt = remain_r;
		burst_nxt = corr_fire ? 7'(burst_r - 7'h01) : burst_r;
		case (cs_r)
			CS_IDLE: begin
				if (trig && mag_live != 7'h00) begin
					cs_nxt = CS_RUN;
					remain_nxt = 7'(mag_live - burst_load);
					burst_nxt = burst_load;
				end
			end
			CS_RUN: begin
				if (min_tick) begin
					remain_nxt = 7'(rem_src - burst_load);
					burst_nxt = burst_load;
				end
				if (remain_nxt == 7'h00 && burst_nxt == 7'h00) begin
					cs_nxt = CS_IDLE;
				end
			end
			default: cs_nxt = CS_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cs_r <= CS_IDLE;
			remain_r <= 7'h00;
			burst_r <= 7'h00;
			sign_l_r <= 1'b0;
			coarse_l_r <= 1'b0;
		end else begin
			cs_r <= cs_nxt;
			remain_r <= remain_nxt;
			burst_r <= burst_nxt;
			if (trig) begin
				sign_l_r <= offs_r.value[6];
				coarse_l_r <= offs_r.coarse;
			end
		end
	end

	// Correction pulse on its pin: 1/128 s low, next one 1/64 s later
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pulse_cnt_r <= 9'h000;
			int_n_r <= 1'b1;
		end else begin
			if (corr_fire && ctl_r[CTL_CIE]) begin
				pulse_cnt_r <= CORR_PULSE_TICKS;
			end else if (tick32 && pulse_cnt_r != 9'h000) begin
				pulse_cnt_r <= 9'(pulse_cnt_r - 9'h001);
			end
			int_n_r <= (pulse_cnt_r == 9'h000) & ~(corr_fire & ctl_r[CTL_CIE]);
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= ~(out_on & ~wave);
		end
	end

	// ----------------------------------------
	// Wishbone slave and registers
	// ----------------------------------------
	// Every access is answered one cycle after it is seen, unmapped too
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= wb_req;
			if (wb_req) begin
				rdat_r <= {24'h000000, rd_byte};
			end
		end
	end

	// Control registers; power-on gives 32768 Hz and zero offset
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			offs_r <= OFFSET_RST;
			tmr_r <= TIMER_RST;
			ctl_r <= 2'h0;
			mask_r <= '0;
		end else begin
			if (wr_offs) begin
				offs_r <= WB_DAT_I[7:0];
			end
			if (wr_tmr) begin
				tmr_r <= WB_DAT_I[7:0] & TIMER_WMASK;
			end
			if (wr_ctl) begin
				ctl_r <= WB_DAT_I[1:0];
			end
			if (wr_mask) begin
				mask_r <= WB_DAT_I[NUM_EV-1:0];
			end
		end
	end

	// Sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			stat_r <= '0;
		end else begin
			stat_r <= ev | (stat_r & ~(wr_stat ? WB_DAT_I[NUM_EV-1:0] : '0));
		end
	end

	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = rdat_r;
	assign IRQ = |(stat_r & mask_r);
	assign CORRECTION_INT_N = int_n_r;
	assign SQUARE_WAVE_OUTPUT_PIN_O = 1'b0;
	assign SQUARE_WAVE_OUTPUT_PIN_OE_N = oe_n_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_corr_cie;
		corr_fire && ctl_r[CTL_CIE];
	endsequence

	a_code7_float: assert property (tmr_r.freq_sel == FSEL_OFF |=> SQUARE_WAVE_OUTPUT_PIN_OE_N)
		else $error("Output driven with code 7");
	a_enpin_float: assert property (!en_s2_r |=> SQUARE_WAVE_OUTPUT_PIN_OE_N)
		else $error("Output driven with enable pin low");
	a_halt_low: assert property (halt && en_s2_r && tmr_r.freq_sel inside {3'h4, 3'h5, 3'h6}
		|=> !SQUARE_WAVE_OUTPUT_PIN_OE_N)
		else $error("Halted slow output not low");
	a_halt_reset: assert property (halt |=> tb_hi_r == 7'h00 && sub_r == 6'h00)
		else $error("Upper prescaler not held");
	a_add_step: assert property (corr_fire && !sign_l_r |=> sub_r == 6'($past(sub_r) + 6'h02))
		else $error("Added pulse not applied");
	a_remove_hold: assert property (corr_fire && sign_l_r |=> $stable(sub_r))
		else $error("Removed pulse not applied");
	a_int_pulse: assert property (s_corr_cie |=> !CORRECTION_INT_N [*8])
		else $error("Correction pulse missing");
	a_burst_bound: assert property (burst_r <= 7'h05)
		else $error("Too many pulses in one minute");
	a_trig_latch: assert property (trig |=> remain_r + burst_r == $past(mag_live))
		else $error("Offset not latched at trigger");
	a_flag_set: assert property (corr_fire |=> stat_r[EV_CORR]) // set wins
		else $error("Correction flag lost");

endmodule

// ===== verif/rtcco_clk_sink.sv
// Purpose: Model of the logic that takes in the square wave output
// Assumes: Open-drain pin with a pull-up on the board
// Notes: Measures the last high and low run lengths in system clock cycles

`timescale 1ns/1ps

module rtcco_clk_sink (
	input wire logic clk,
	input wire logic pin_o,
	input wire logic pin_oe_n,
	output logic lvl,
	output logic [15:0] hi_len,
	output logic [15:0] lo_len,
	output logic [15:0] edges
);
	// ----------------------------------------
	// Wire level and run-length meter
	// ----------------------------------------
	logic [15:0] run_r; // Cycles spent at the current level
	logic prev_r; // Level seen one cycle ago

	// Released pin rises through the pull-up, never shows a stale drive
	assign lvl = pin_oe_n ? 1'b1 : pin_o;

	initial begin
		run_r = 16'h0000;
		prev_r = 1'b1;
		hi_len = 16'h0000;
		lo_len = 16'h0000;
		edges = 16'h0000;
	end

	// A run is closed at each change of level; the consumer only sees edges
	always @(posedge clk) begin
		if (lvl != prev_r) begin
			if (prev_r) begin
				hi_len <= run_r;
			end else begin
				lo_len <= run_r;
			end
			edges <= edges + 16'h0001;
			run_r <= 16'h0001;
		end else begin
			run_r <= run_r + 16'h0001;
		end
		prev_r <= lvl;
	end
endmodule

// ===== verif/tb.sv
// Purpose: Self-checking bench for the clock output and offset block
// Assumes: Crystal input toggled every two system cycles, so one tick is 4 cycles
// Notes: Correction runs need minutes of crystal time and are left to the inline checks

`timescale 1ns/1ps

module tb
	import rtcco_pkg::*;
;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic xtal = 1'b0;
	logic xdiv = 1'b0;
	logic oepin = 1'b1; // Enable pin, high lets the wave out
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h1;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] dat_o;
	logic ack, irq, pin_o, pin_oe_n, corr_n, lvl;
	logic [15:0] hi_len, lo_len, edges;
	int err_total = 0;
	int n_checks = 0;
	int cyc_cnt = 0;

	always #2 sys_clk = ~sys_clk;

	// Fast crystal keeps the divided rates down to 1024 Hz inside a short run
	always @(posedge sys_clk) begin
		xdiv <= ~xdiv;
		if (xdiv) begin
			xtal <= ~xtal;
		end
	end

	rtcco_top dut (.SYS_CLK(sys_clk), .RSTN(rstn), .XTAL_IN(xtal), .OUTPUT_ENABLE_PIN(oepin),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ(irq),
		.SQUARE_WAVE_OUTPUT_PIN_O(pin_o), .SQUARE_WAVE_OUTPUT_PIN_OE_N(pin_oe_n),
		.CORRECTION_INT_N(corr_n));

	rtcco_clk_sink sink (.clk(sys_clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .lvl(lvl),
		.hi_len(hi_len), .lo_len(lo_len), .edges(edges));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic cycle: hold the request until ack is sampled high, then drop it
	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h000000, wd};
		@(posedge sys_clk);
		// No limit of its own: a lost answer is ended by the hang guard
		while (ack !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Pin must stay still at the expected level for a while
	task automatic quiet(input logic [15:0] exp_lvl);
		logic [15:0] e;
		repeat (20) @(posedge sys_clk);
		e = edges;
		repeat (150) @(posedge sys_clk);
		chk(edges, e);
		chk({15'h0000, lvl}, exp_lvl);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [7:0] r;
		wb(1'b0, IDX_TIMER, 8'h00, r);
		chk({8'h00, r}, {8'h00, TIMER_RST});
		wb(1'b0, IDX_OFFSET, 8'h00, r);
		chk({8'h00, r}, 16'h0000);
		wb(1'b1, IDX_OFFSET, 8'hC0, r);
		wb(1'b0, IDX_OFFSET, 8'h00, r);
		chk({8'h00, r}, 16'h00C0);
		wb(1'b1, IDX_OFFSET, 8'h3F, r);
		wb(1'b0, IDX_OFFSET, 8'h00, r);
		chk({8'h00, r}, 16'h003F);
		wb(1'b1, 6'h20, 8'hFF, r);
		wb(1'b0, 6'h20, 8'h00, r);
		chk({8'h00, r}, 16'h0000);
		wb(1'b1, IDX_TIMER, 8'hFF, r);
		wb(1'b0, IDX_TIMER, 8'h00, r);
		chk({8'h00, r}, 16'h007B);
		quiet(16'h0001); // code 7 releases the pin
	endtask

	// Codes 1 to 5 halve the rate each step with equal high and low time
	task automatic t_freq();
		logic [7:0] r;
		for (int k = 1; k < 6; k++) begin
			wb(1'b1, IDX_TIMER, 8'(k << 4), r);
			repeat (300) @(posedge sys_clk);
			chk(hi_len, 16'(2 << k));
			chk(lo_len, 16'(2 << k));
		end
	endtask

	task automatic t_halt();
		logic [7:0] r;
		wb(1'b1, IDX_CTRL, 8'h01, r);
		wb(1'b1, IDX_TIMER, 8'h30, r);
		repeat (100) @(posedge sys_clk);
		chk(hi_len, 16'h0010);
		for (int k = 4; k < 7; k++) begin
			wb(1'b1, IDX_TIMER, 8'(k << 4), r);
			quiet(16'h0000);
		end
		wb(1'b1, IDX_CTRL, 8'h00, r);
	endtask

	task automatic t_enable();
		logic [7:0] r;
		logic [15:0] e;
		wb(1'b1, IDX_TIMER, 8'h10, r);
		oepin <= 1'b0;
		quiet(16'h0001);
		chk({15'h0000, pin_oe_n}, 16'h0001);
		oepin <= 1'b1;
		e = edges;
		repeat (60) @(posedge sys_clk);
		chk({15'h0000, edges > e + 16'h0008}, 16'h0001);
	endtask

	// No event can be forced here; check mask, clear and level agree
	task automatic t_irq();
		logic [7:0] r;
		wb(1'b1, IDX_MASK, 8'h07, r);
		wb(1'b0, IDX_MASK, 8'h00, r);
		chk({8'h00, r}, 16'h0007);
		// No minute passes in so short a run, so no flag can be set yet
		wb(1'b0, IDX_STATUS, 8'h00, r);
		chk({8'h00, r}, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wb(1'b1, IDX_STATUS, 8'h07, r);
		wb(1'b0, IDX_STATUS, 8'h00, r);
		chk({8'h00, r}, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wb(1'b1, IDX_CTRL, 8'h03, r);
		wb(1'b0, IDX_CTRL, 8'h00, r);
		chk({8'h00, r}, 16'h0003);
		// Enabling the pulse alone must not pull the correction pin low
		repeat (20) @(posedge sys_clk);
		chk({15'h0000, corr_n}, 16'h0001);
	endtask

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 30000) begin
			err_total++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		chk({15'h0000, pin_oe_n}, 16'h0001);
		chk({15'h0000, pin_o}, 16'h0000); // Open drain only pulls low
		rstn <= 1'b1;
		repeat (60) @(posedge sys_clk);
		chk({15'h0000, edges >= 16'h0010}, 16'h0001);
		t_regs();
		t_freq();
		t_halt();
		t_enable();
		t_irq();
		end_of_test();
	end
endmodule
